// [verilog/ntr_pkg.sv]
// Purpose: shared constants for the non-transparent address remap block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   offsets are byte addresses of aligned words
package ntr_pkg;
   // ***********************************************************
   // register offsets
   // ***********************************************************
   localparam logic [11:0] OFF_CTRL     = 12'h068; // control + pri lower base
   localparam logic [11:0] OFF_PRI_UB   = 12'h06C; // primary upper base
   localparam logic [11:0] OFF_SEC_LB   = 12'h070; // secondary lower base
   localparam logic [11:0] OFF_SEC_UB   = 12'h074; // secondary upper base
   localparam logic [11:0] OFF_SEC_LL   = 12'h078; // secondary lower limit
   localparam logic [11:0] OFF_SEC_UL   = 12'h07C; // secondary upper limit
   // ***********************************************************
   // field layout and reset values
   // ***********************************************************
   localparam int          ENABLE_BIT   = 3;       // remap_enable position
   localparam int          BASE_LSB     = 20;      // 1 MB granule field lsb
   localparam logic [31:0] MASK_CTRL    = 32'hFFF0_0008; // writable bits
   localparam logic [31:0] MASK_LOWER   = 32'hFFF0_0000; // lower base/limit
   localparam logic [31:0] MASK_FULL    = 32'hFFFF_FFFF; // upper words
   localparam logic [31:0] RESET_VALUE  = 32'h0000_0000; // all registers
   localparam int          NUM_REGS     = 6;       // register count
   // ***********************************************************
   // AXI response codes
   // ***********************************************************
   localparam logic [1:0]  RESP_OKAY    = 2'h0;    // mapped access
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;    // unmapped access
endpackage

// [verilog/ntr_regfile.sv]
// Purpose: six-word register store for the remap block
// Assumes: one write port, one registered read port
// Notes:   per-register write masks drop reserved bits
`timescale 1ns/1ps
module ntr_regfile (
   input  wire logic        aclk,      // core clock
   input  wire logic        aresetn,   // sync reset, active low
   input  wire logic        wr_en,     // write strobe
   input  wire logic [2:0]  wr_idx,    // write register index
   input  wire logic [31:0] wr_data,   // write data
   input  wire logic [3:0]  wr_strb,   // byte enables
   input  wire logic        rd_en,     // read strobe
   input  wire logic [2:0]  rd_idx,    // read register index
   output logic      [31:0] rd_data,   // registered read data
   output logic      [191:0] flat      // all registers, idx 0 lowest
);
   // ***********************************************************
   // storage
   // ***********************************************************
   logic [31:0] regs      [ntr_pkg::NUM_REGS]; // register words
   logic [31:0] next_regs [ntr_pkg::NUM_REGS]; // next words
   logic [31:0] next_rd_data;                  // next read data

   // writable mask by index; reserved bits never store
   function automatic logic [31:0] wmask(input logic [2:0] idx);
      unique case (idx)
         3'h0:           wmask = ntr_pkg::MASK_CTRL;
         3'h2, 3'h4:     wmask = ntr_pkg::MASK_LOWER;
         default:        wmask = ntr_pkg::MASK_FULL;
      endcase
   endfunction

   // next-state for words and read port
   always_comb begin
      logic [31:0] bm;
      bm = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
            {8{wr_strb[0]}}} & wmask(wr_idx);
      for (int i = 0; i < ntr_pkg::NUM_REGS; i++) begin
         next_regs[i] = regs[i];
      end
      if (wr_en) begin
         next_regs[wr_idx] = (regs[wr_idx] & ~bm) | (wr_data & bm);
      end
      next_rd_data = rd_data;
      if (rd_en) begin
         next_rd_data = regs[rd_idx];
      end
   end

   // register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < ntr_pkg::NUM_REGS; i++) begin
            regs[i] <= ntr_pkg::RESET_VALUE;
         end
         rd_data <= ntr_pkg::RESET_VALUE;
      end else begin
         for (int i = 0; i < ntr_pkg::NUM_REGS; i++) begin
            regs[i] <= next_regs[i];
         end
         rd_data <= next_rd_data;
      end
   end

   // flat view for the translator
   always_comb begin
      for (int i = 0; i < ntr_pkg::NUM_REGS; i++) begin
         flat[i*32 +: 32] = regs[i];
      end
   end
endmodule

// [verilog/ntr_xlate.sv]
// Purpose: one-cycle address window check and rebase
// Assumes: 64-bit addresses, window registers stable during a lookup
// Notes:   result registered; one lookup per cycle
`timescale 1ns/1ps
module ntr_xlate (
   input  wire logic        aclk,       // core clock
   input  wire logic        aresetn,    // sync reset, active low
   input  wire logic        in_valid,   // address offered
   input  wire logic [63:0] in_addr,    // incoming address
   input  wire logic        enable,     // remap_enable
   input  wire logic [63:0] pri_base,   // primary base
   input  wire logic [63:0] sec_base,   // secondary base
   input  wire logic [63:0] sec_limit,  // secondary limit
   output logic             out_valid,  // result valid pulse
   output logic      [63:0] out_addr,   // translated or passed address
   output logic             out_hit     // address was remapped
);
   logic        hit;          // window hit this cycle
   logic        next_valid;   // next out_valid
   logic [63:0] next_addr;    // next out_addr
   logic        next_hit;     // next out_hit

   // compare inclusive window, swap base, keep the offset
   always_comb begin
      hit = enable && (in_addr >= sec_base) && (in_addr <= sec_limit);
      next_valid = in_valid;
      next_hit   = in_valid && hit;
      next_addr  = in_valid ? in_addr : out_addr;
      if (in_valid && hit) begin
         next_addr = in_addr - sec_base + pri_base;
      end
   end

   // result stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_addr  <= 64'h0000_0000_0000_0000;
         out_hit   <= 1'b0;
      end else begin
         out_valid <= next_valid;
         out_addr  <= next_addr;
         out_hit   <= next_hit;
      end
   end
endmodule

// [verilog/ntr_remap.sv]
// Purpose: non-transparent upstream address remap with AXI4-Lite regs
// Assumes: single clock, synchronous active-low reset
// Notes:   register writes steer lookups that start after the write
//
// Functional notes
// - redirect addresses inside window to new location
// - remap only while control bit 3 set
// - control bits 31:20 hold primary lower base
// - primary upper base: full 32-bit word
// - secondary lower base in bits 31:20
// - secondary upper base: full 32-bit word
// - secondary lower limit in bits 31:20
// - secondary upper limit: full 32-bit word
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ntr_remap (
   input  wire logic        aclk,          // core clock, 40 MHz
   input  wire logic        aresetn,       // sync reset, active low
   input  wire logic [11:0] s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic      [1:0]  s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [11:0] s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic      [31:0] s_axi_rdata,   // read data
   output logic      [1:0]  s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   input  wire logic        txn_valid,     // transaction address offered
   input  wire logic [63:0] txn_addr,      // transaction address
   output logic             remap_valid,   // translated result valid
   output logic      [63:0] remap_addr,    // translated address
   output logic             remap_hit,     // result was remapped
   output logic             remap_active   // remap_enable mirror
);
   // ***********************************************************
   // decode helper
   // ***********************************************************
   // map a byte offset to a register index; bit 3 flags unmapped
   function automatic logic [3:0] decode(input logic [11:0] a);
      unique case (a)
         ntr_pkg::OFF_CTRL:   decode = 4'h0;
         ntr_pkg::OFF_PRI_UB: decode = 4'h1;
         ntr_pkg::OFF_SEC_LB: decode = 4'h2;
         ntr_pkg::OFF_SEC_UB: decode = 4'h3;
         ntr_pkg::OFF_SEC_LL: decode = 4'h4;
         ntr_pkg::OFF_SEC_UL: decode = 4'h5;
         default:             decode = 4'h8;
      endcase
   endfunction

   // ***********************************************************
   // write channel
   // ***********************************************************
   logic        aw_held, next_aw_held;     // address captured
   logic [11:0] aw_addr, next_aw_addr;     // captured address
   logic        w_held, next_w_held;       // data captured
   logic [31:0] w_data, next_w_data;       // captured data
   logic [3:0]  w_strb, next_w_strb;       // captured strobes
   logic        next_awready, next_wready; // next readies
   logic        next_bvalid;               // next bvalid
   logic [1:0]  next_bresp;                // next bresp
   logic        wr_fire;                   // commit the write
   logic [3:0]  wr_dec;                    // decoded write index

   // address and data arrive in either order; commit once both held
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      wr_dec       = decode(aw_addr);
      wr_fire      = aw_held && w_held && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         // unmapped offsets store nothing and answer an error
         next_bresp   = wr_dec[3] ? ntr_pkg::RESP_SLVERR
                                  : ntr_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // ready only while the slot is empty: one write in flight
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   // write channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= 12'h000;
         w_held        <= 1'b0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ntr_pkg::RESP_OKAY;
      end else begin
         aw_held       <= next_aw_held;
         aw_addr       <= next_aw_addr;
         w_held        <= next_w_held;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
      end
   end

   // ***********************************************************
   // read channel
   // ***********************************************************
   logic       rd_pend, next_rd_pend;   // read data due next cycle
   logic       rd_bad, next_rd_bad;     // pending read is unmapped
   logic       next_arready;            // next arready
   logic       next_rvalid;             // next rvalid
   logic [1:0] next_rresp;              // next rresp
   logic       rd_take;                 // address accepted
   logic [3:0] rd_dec;                  // decoded read index
   logic [31:0] rf_rdata;               // store read port

   // two-step read: store reads on accept, data shown next cycle
   always_comb begin
      rd_take      = s_axi_arvalid && s_axi_arready;
      rd_dec       = decode(s_axi_araddr);
      next_rd_pend = rd_take;
      next_rd_bad  = rd_take ? rd_dec[3] : rd_bad;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      if (rd_pend) begin
         next_rvalid = 1'b1;
         next_rresp  = rd_bad ? ntr_pkg::RESP_SLVERR : ntr_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      next_arready = !rd_take && !rd_pend && !next_rvalid;
   end

   // read channel registers; rdata latched with rvalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_pend       <= 1'b0;
         rd_bad        <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= ntr_pkg::RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         rd_pend       <= next_rd_pend;
         rd_bad        <= next_rd_bad;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         if (rd_pend) begin
            s_axi_rdata <= rd_bad ? 32'h0000_0000 : rf_rdata;
         end
      end
   end

   // ***********************************************************
   // register store and translator
   // ***********************************************************
   logic [191:0] regs_flat;   // all six words
   logic [31:0]  ctrl_w;      // control word
   logic [63:0]  pri_base;    // primary base
   logic [63:0]  sec_base;    // secondary base
   logic [63:0]  sec_limit;   // secondary limit
   logic         xl_valid;    // translator result valid
   logic [63:0]  xl_addr;     // translator result address
   logic         xl_hit;      // translator hit

   ntr_regfile u_regs (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (wr_fire && !wr_dec[3]),
      .wr_idx  (wr_dec[2:0]),
      .wr_data (w_data),
      .wr_strb (w_strb),
      .rd_en   (rd_take && !rd_dec[3]),
      .rd_idx  (rd_dec[2:0]),
      .rd_data (rf_rdata),
      .flat    (regs_flat)
   );

   // low 20 bits of a lower word always zero: limit covers its 1 MB
   always_comb begin
      ctrl_w    = regs_flat[31:0];
      pri_base  = {regs_flat[63:32], ctrl_w[31:20], 20'h00000};
      sec_base  = {regs_flat[127:96], regs_flat[95:84],
                   20'h00000};
      sec_limit = {regs_flat[191:160], regs_flat[159:148],
                   20'hFFFFF};
   end

   ntr_xlate u_xlate (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (txn_valid),
      .in_addr   (txn_addr),
      .enable    (ctrl_w[ntr_pkg::ENABLE_BIT]),
      .pri_base  (pri_base),
      .sec_base  (sec_base),
      .sec_limit (sec_limit),
      .out_valid (xl_valid),
      .out_addr  (xl_addr),
      .out_hit   (xl_hit)
   );

   // outputs straight from flops
   always_comb begin
      remap_valid = xl_valid;
      remap_addr  = xl_addr;
      remap_hit   = xl_hit;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         remap_active <= 1'b0;
      end else begin
         remap_active <= ctrl_w[ntr_pkg::ENABLE_BIT];
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   // lookup results reflect the window as it stood one edge earlier
   hit_needs_enable_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      remap_hit |-> $past(ctrl_w[ntr_pkg::ENABLE_BIT]))
      else $error("remap hit while disabled");
   miss_passes_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(txn_valid) && !remap_hit |-> remap_addr == $past(txn_addr))
      else $error("missed address altered");
   hit_rebased_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      remap_hit |-> remap_addr == $past(txn_addr) - $past(sec_base)
                    + $past(pri_base))
      else $error("hit address wrong");
   hit_in_window_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      remap_hit |-> $past(txn_addr) >= $past(sec_base)
                    && $past(txn_addr) <= $past(sec_limit))
      else $error("hit outside window");
   hit_when_inside_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(txn_valid)
      && $past(ctrl_w[ntr_pkg::ENABLE_BIT])
      && $past(txn_addr) >= $past(sec_base)
      && $past(txn_addr) <= $past(sec_limit) |-> remap_hit)
      else $error("in-window address not remapped");
   lookup_pulse_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> remap_valid == $past(txn_valid))
      else $error("lookup result not one cycle later");
   active_mirror_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> remap_active == $past(ctrl_w[ntr_pkg::ENABLE_BIT]))
      else $error("remap status does not follow enable");
   ctrl_reserved_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (ctrl_w & ~ntr_pkg::MASK_CTRL) == 32'h0000_0000)
      else $error("control reserved bit set");
   sec_base_res_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      regs_flat[83:64] == 20'h00000)
      else $error("base reserved bits set");
   sec_limit_res_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      regs_flat[147:128] == 20'h00000)
      else $error("limit reserved bits set");
   read_latency_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read answer late");
   write_resp_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid)
      else $error("write response missing");
   one_write_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answer pending");
endmodule

// [verification/ntr_txn_model.sv]
// Purpose: model of the upstream link that offers lookup addresses
// Assumes: one address per cycle while issue is high
// Notes:   idle address inverts every cycle so no stale value lingers
`timescale 1ns/1ps
module ntr_txn_model (
   input  wire logic        aclk,       // core clock
   input  wire logic        aresetn,    // sync reset, active low
   input  wire logic        issue,      // bench asks for a lookup
   input  wire logic [63:0] issue_addr, // address to offer
   output logic             txn_valid,  // lookup strobe
   output logic      [63:0] txn_addr    // offered address
);
   // ***********************************************************
   // link driver: strobe follows issue, address garbles when idle
   // ***********************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txn_valid <= 1'b0;
         txn_addr  <= 64'h0;
      end else begin
         txn_valid <= issue;
         txn_addr  <= issue ? issue_addr : ~txn_addr;
      end
   end
endmodule

// [verification/tb.sv]
// Purpose: self-checking bench for the address remap block
// Assumes: AXI4-Lite master here, link model issues lookups
// Notes:   expected results queue up, a monitor pops and compares
`timescale 1ns/1ps
module tb;
   // ***********************************************************
   // signals
   // ***********************************************************
   logic        aclk = 1'b0, aresetn = 1'b0;   // clock, reset
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        bready = 1'b0, rready = 1'b0; // held high after reset
   logic        awready, wready, arready, bvalid, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        issue = 1'b0;                  // lookup request
   logic [63:0] issue_addr = 64'h0;
   logic        txn_valid, remap_valid, remap_hit, remap_active;
   logic [63:0] txn_addr, remap_addr;
   logic [31:0] sh [6];                        // bench copy of registers
   logic [31:0] msk [6] = '{ntr_pkg::MASK_CTRL, ntr_pkg::MASK_FULL,
      ntr_pkg::MASK_LOWER, ntr_pkg::MASK_FULL, ntr_pkg::MASK_LOWER,
      ntr_pkg::MASK_FULL};
   logic [31:0] seed = 32'd13622;              // xorshift state
   logic [64:0] q_b [$], q_r [$], q_l [$];     // expected results
   int          bad_count = 0, samples_checked = 0, cycles = 0;

   always #12.5 aclk = ~aclk;                  // 25 ns period

   ntr_remap u_ntr_remap (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .txn_valid(txn_valid), .txn_addr(txn_addr),
      .remap_valid(remap_valid), .remap_addr(remap_addr),
      .remap_hit(remap_hit), .remap_active(remap_active));

   ntr_txn_model u_ntr_txn_model (.aclk(aclk), .aresetn(aresetn),
      .issue(issue), .issue_addr(issue_addr),
      .txn_valid(txn_valid), .txn_addr(txn_addr));

   // ***********************************************************
   // helpers
   // ***********************************************************
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // reference window: inclusive ends, 1 MB granule, base swapped
   function automatic logic [64:0] xl(input logic [63:0] a);
      logic [63:0] sb, sl, pb;
      sb = {sh[3], sh[2][31:20], 20'h00000};
      sl = {sh[5], sh[4][31:20], 20'hFFFFF};
      pb = {sh[1], sh[0][31:20], 20'h00000};
      if (sh[0][3] && a >= sb && a <= sl)
         return {1'b1, a - sb + pb};
      return {1'b0, a};
   endfunction

   task automatic check(input logic [64:0] seen, input logic [64:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // write: aw and w offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic aw_ok, w_ok, hit;
      int   i;
      hit = a >= 12'h068 && a <= 12'h07C;
      i = hit ? (a - 12'h068) >> 2 : 0;
      q_b.push_back({63'h0, hit ? ntr_pkg::RESP_OKAY : ntr_pkg::RESP_SLVERR});
      if (hit) begin
         for (int b = 0; b < 4; b++)
            if (s[b]) sh[i][8*b +: 8] = d[8*b +: 8];
         sh[i] = sh[i] & msk[i];              // reserved bits dropped
      end
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
   endtask

   task automatic rd(input logic [11:0] a);
      logic hit;
      hit = a >= 12'h068 && a <= 12'h07C;
      q_r.push_back(hit ? {31'h0, ntr_pkg::RESP_OKAY, sh[(a - 12'h068) >> 2]}
                        : {31'h0, ntr_pkg::RESP_SLVERR, 32'h0});
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
   endtask

   // one lookup per call; callers chain them back to back
   task automatic lk(input logic [63:0] a);
      q_l.push_back(xl(a));
      issue      <= 1'b1;
      issue_addr <= a;
      @(posedge aclk);
   endtask

   // ***********************************************************
   // monitor: oldest expectation against each answer
   // ***********************************************************
   always @(posedge aclk) begin
      if (aresetn && bvalid && bready)
         check({63'h0, bresp}, q_b.pop_front());
      if (aresetn && rvalid && rready)
         check({31'h0, rresp, rdata}, q_r.pop_front());
      if (aresetn && remap_valid) begin
         if (q_l.size() == 0)
            check(65'h1, 65'h0);
         else
            check({remap_hit, remap_addr}, q_l.pop_front());
      end
   end

   // hang guard: the run needs well under a thousand cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      for (int i = 0; i < 6; i++) sh[i] = ntr_pkg::RESET_VALUE;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      bready <= 1'b1;
      rready <= 1'b1;
      // reset values, then one unmapped word past the block
      for (int i = 0; i < 7; i++) rd(12'h068 + 12'(4 * i));
      wr(12'h080, 32'hFFFFFFFF, 4'hF);
      // all ones into each word, reserved bits must read back zero
      for (int i = 0; i < 6; i++) begin
         wr(12'h068 + 12'(4 * i), 32'hFFFFFFFF, 4'hF);
         rd(12'h068 + 12'(4 * i));
      end
      wr(12'h06C, xs(), 4'h6);
      rd(12'h06C);
      // window 0x1_0010_0000 .. 0x1_003F_FFFF, random primary base
      wr(12'h074, 32'h00000001, 4'hF);
      wr(12'h070, 32'h00100000 | (xs() & 32'h000FFFFF), 4'hF);
      wr(12'h07C, 32'h00000001, 4'hF);
      wr(12'h078, 32'h00300000, 4'hF);
      wr(12'h06C, xs(), 4'hF);
      wr(12'h068, xs() | 32'h00000008, 4'hF);
      repeat (2) @(posedge aclk);
      check({64'h0, remap_active}, {64'h0, sh[0][3]});
      // edges of the window, then random addresses back to back
      lk(64'h1_000F_FFFF);
      lk(64'h1_0010_0000);
      lk(64'h1_003F_FFFF);
      lk(64'h1_0040_0000);
      for (int i = 0; i < 16; i++) lk({32'h1, xs() & 32'h007FFFFF});
      issue <= 1'b0;               // end the chain before the write
      // disable mid-stream: in-window addresses must pass unchanged
      wr(12'h068, sh[0] & 32'hFFFFFFF7, 4'hF);
      lk(64'h1_0010_0000);
      lk(64'h1_0020_0000);
      issue <= 1'b0;
      repeat (4) @(posedge aclk);
      check({64'h0, remap_active}, 65'h0);
      check(65'(q_b.size() + q_r.size() + q_l.size()), 65'h0);
      stop_test();
   end
endmodule
